// ==== common/sios_pkg.sv ====
// package of constants and types for the special output sequencer
// ---------------------------------------------------------------
// Summary of operation
// (RQ1) block forms read memory at the source pointer and write it to the io address held in the destination.
// (RQ2) every special io address is driven as a 16-bit value.
// (RQ3) the repeating incrementing form advances the source pointer by one for bytes or two for words.
// (RQ4) the repeating form decrements the counter per element and repeats until it reaches zero.
// (RQ5) software loads a counter giving 1 to 65536 bytes and no more than 32768 words.
// (RQ6) the repeating form takes 11 cycles plus 10 per element, word and byte alike.
// (RQ7) the repeating form takes interrupts between elements and saves the start pc first.
// (RQ8) each accepted interrupt adds seven cycles to the instruction.
// (RQ9) every form runs only in the privileged state.
// (RQ10) the status outputs signal a special io reference during each io transfer.
// (RQ11) the direct form writes the data register to the given io address in 12 cycles.
// (RQ12) the direct form leaves all flags unchanged.
// (RQ13) the decrementing form moves one element, steps the pointer back by one or two, counts once, in 21 cycles.
// (RQ14) the decrementing form sets overflow when the counter reaches zero, else clears it.
// (RQ15) the repeating form sets overflow on completion and keeps the other flags.
// (RQ16) a form started outside the privileged state traps and moves nothing.
// ---------------------------------------------------------------
package sios_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_PC = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_CYC = 8'h20;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_GO = 0;
  localparam int CTRL_FORM_LO = 1;
  localparam int CTRL_BYTE = 3;
  localparam int CTRL_PRIV = 4;

  // flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_S = 2;
  localparam int FLG_V = 3;
  localparam int FLG_D = 4;
  localparam int FLG_H = 5;
  localparam int FLG_W = 6;

  // status positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TRAP = 2;
  localparam int ST_SUSP = 3;

  // ---------------------------------------------------------------
  // timing counts in processor cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] SETUP_BLOCK = 4'hB;
  localparam logic [3:0] SETUP_DIRECT = 4'h2;
  localparam logic [3:0] ELEM_LEN = 4'hA;
  localparam logic [3:0] IRQ_LEN = 4'h7;
  localparam logic [3:0] E_READ = 4'h0;
  localparam logic [3:0] E_CAPT = 4'h1;
  localparam logic [3:0] E_PUSH = 4'h2;

  // bus status codes
  localparam logic [3:0] STATUS_IDLE = 4'h0;
  localparam logic [3:0] STATUS_SPECIAL_IO = 4'h3;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_PC = 32'h0000_0000;

  typedef enum logic [1:0] {
    FORM_DIRECT = 2'b00,
    FORM_INC_REPEAT = 2'b01,
    FORM_DEC = 2'b10
  } sios_form_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_ELEM = 3'b010,
    S_IRQ = 3'b011
  } sios_state_t;

endpackage : sios_pkg

// ==== hw/sios_fifo.sv ====
// synchronous fifo with valid and ready on both sides
module sios_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overrun : assert property (@(posedge ref_clk) disable iff (rst)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule : sios_fifo

// ==== hw/sios_top.sv ====
// special output sequencer: apb registers, timing engine and io port
//
// Local design decisions: the APB slave port and the placing of the registers.
module sios_top #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic irq_req,
  output logic irq_ack,
  output logic [31:0] saved_pc,
  output logic priv_trap,
  output logic io_valid,
  input wire logic io_ready,
  output logic [15:0] io_addr,
  output logic [15:0] io_data,
  output logic io_byte,
  output logic [3:0] io_status
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  sios_pkg::sios_state_t state_q;
  sios_pkg::sios_form_t form_q;
  logic byte_q;
  logic priv_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [15:0] cnt_q;
  logic [15:0] data_q;
  logic [6:0] flags_q;
  logic [31:0] pc_q;
  logic [15:0] cyc_q;
  logic [3:0] ph_q;
  logic [15:0] elem_q;
  logic done_q;
  logic trap_q;
  logic susp_q;
  logic [15:0] cnt_dec;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic go;
  logic busy;
  logic push;
  logic fifo_ready;
  logic elem_end;
  logic [32:0] fifo_out;

  function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                           input logic b,
                                           input logic up);
    logic [15:0] d;
    d = b ? 16'h0001 : 16'h0002;
    step_ptr = up ? p + d : p - d;
  endfunction : step_ptr

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign busy = (state_q != sios_pkg::S_IDLE);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign go = wr_en && (paddr == sios_pkg::OFS_CTRL)
           && pwdata[sios_pkg::CTRL_GO] && !busy;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      sios_pkg::OFS_CTRL, sios_pkg::OFS_SRC, sios_pkg::OFS_DST,
      sios_pkg::OFS_CNT, sios_pkg::OFS_DATA, sios_pkg::OFS_FLAGS,
      sios_pkg::OFS_PC, sios_pkg::OFS_STAT, sios_pkg::OFS_CYC: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      unique case (paddr)
        sios_pkg::OFS_CTRL: prdata <= {27'h0, priv_q, byte_q, form_q, 1'b0};
        sios_pkg::OFS_SRC: prdata <= {16'h0, src_q};
        sios_pkg::OFS_DST: prdata <= {16'h0, dst_q};
        sios_pkg::OFS_CNT: prdata <= {16'h0, cnt_q};
        sios_pkg::OFS_DATA: prdata <= {16'h0, data_q};
        sios_pkg::OFS_FLAGS: prdata <= {25'h0, flags_q};
        sios_pkg::OFS_PC: prdata <= pc_q;
        sios_pkg::OFS_STAT: prdata <= {28'h0, susp_q, trap_q, done_q, busy};
        sios_pkg::OFS_CYC: prdata <= {16'h0, cyc_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration written only while idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      form_q <= sios_pkg::FORM_DIRECT;
      byte_q <= 1'b0;
      priv_q <= 1'b0;
      dst_q <= sios_pkg::RST_WORD;
      data_q <= sios_pkg::RST_WORD;
      pc_q <= sios_pkg::RST_PC;
    end else if (wr_en && !busy) begin
      unique case (paddr)
        sios_pkg::OFS_CTRL: begin
          form_q <= sios_pkg::sios_form_t'(pwdata[2:1]);
          byte_q <= pwdata[sios_pkg::CTRL_BYTE];
          priv_q <= pwdata[sios_pkg::CTRL_PRIV];
        end
        sios_pkg::OFS_DST: dst_q <= pwdata[15:0];
        sios_pkg::OFS_DATA: data_q <= pwdata[15:0];
        sios_pkg::OFS_PC: pc_q <= pwdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign cnt_dec = cnt_q - 16'h0001;
  assign elem_end = (state_q == sios_pkg::S_ELEM)
                 && (ph_q == sios_pkg::ELEM_LEN - 4'h1);
  assign push = (state_q == sios_pkg::S_ELEM)
             && (ph_q == sios_pkg::E_PUSH);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= sios_pkg::S_IDLE;
      ph_q <= 4'h0;
    end else begin
      unique case (state_q)
        sios_pkg::S_IDLE: begin
          if (go && pwdata[sios_pkg::CTRL_PRIV]) begin // [RQ9]
            state_q <= sios_pkg::S_SETUP;
            ph_q <= 4'h0;
          end
        end
        sios_pkg::S_SETUP: begin
          if (ph_q == ((form_q == sios_pkg::FORM_DIRECT) ?
              sios_pkg::SETUP_DIRECT : sios_pkg::SETUP_BLOCK) - 4'h1) begin
            state_q <= sios_pkg::S_ELEM; // [RQ6] [RQ11] [RQ13]
            ph_q <= 4'h0;
          end else begin
            ph_q <= ph_q + 4'h1;
          end
        end
        sios_pkg::S_ELEM: begin
          if (push && !fifo_ready) begin
            ph_q <= ph_q;
          end else if (elem_end) begin
            ph_q <= 4'h0;
            if (form_q != sios_pkg::FORM_INC_REPEAT || cnt_dec == 16'h0) begin
              state_q <= sios_pkg::S_IDLE; // [RQ4]
            end else if (irq_req) begin
              state_q <= sios_pkg::S_IRQ; // [RQ7]
            end
          end else begin
            ph_q <= ph_q + 4'h1;
          end
        end
        sios_pkg::S_IRQ: begin
          if (ph_q == sios_pkg::IRQ_LEN - 4'h1) begin
            state_q <= sios_pkg::S_IDLE; // [RQ8]
            ph_q <= 4'h0;
          end else begin
            ph_q <= ph_q + 4'h1;
          end
        end
        default: begin
          state_q <= sios_pkg::S_IDLE;
          ph_q <= 4'h0;
        end
      endcase
    end
  end

  // pointer and counter, software may load them while idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_q <= sios_pkg::RST_WORD;
      cnt_q <= sios_pkg::RST_WORD;
    end else if (elem_end && form_q != sios_pkg::FORM_DIRECT) begin
      src_q <= step_ptr(src_q, byte_q,
                        form_q == sios_pkg::FORM_INC_REPEAT); // [RQ3] [RQ13]
      cnt_q <= cnt_dec; // [RQ4] [RQ13]
    end else if (wr_en && !busy && paddr == sios_pkg::OFS_SRC) begin
      src_q <= pwdata[15:0];
    end else if (wr_en && !busy && paddr == sios_pkg::OFS_CNT) begin
      cnt_q <= pwdata[15:0];
    end
  end

  // flags: only overflow is written by the block forms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_q <= 7'h00;
    end else if (elem_end && form_q == sios_pkg::FORM_DEC) begin
      flags_q[sios_pkg::FLG_V] <= (cnt_dec == 16'h0); // [RQ14]
    end else if (elem_end && form_q == sios_pkg::FORM_INC_REPEAT
                 && cnt_dec == 16'h0) begin
      flags_q[sios_pkg::FLG_V] <= 1'b1; // [RQ15]
    end else if (wr_en && !busy && paddr == sios_pkg::OFS_FLAGS) begin
      flags_q <= pwdata[6:0];
    end
  end

  // cycle count of the current instruction, irq cycles included
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_q <= sios_pkg::RST_WORD;
      elem_q <= sios_pkg::RST_WORD;
    end else if (go) begin
      cyc_q <= sios_pkg::RST_WORD;
      elem_q <= sios_pkg::RST_WORD;
    end else if (busy) begin
      cyc_q <= cyc_q + 16'h0001;
      elem_q <= elem_end ? elem_q + 16'h0001 : elem_q;
    end
  end

  // status bits and pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q <= 1'b0;
      trap_q <= 1'b0;
      susp_q <= 1'b0;
      priv_trap <= 1'b0;
      irq_ack <= 1'b0;
      saved_pc <= sios_pkg::RST_PC;
    end else begin
      priv_trap <= go && !pwdata[sios_pkg::CTRL_PRIV]; // [RQ16]
      irq_ack <= (state_q == sios_pkg::S_IRQ)
              && (ph_q == sios_pkg::IRQ_LEN - 4'h1);
      if (go) begin
        done_q <= 1'b0;
        trap_q <= !pwdata[sios_pkg::CTRL_PRIV]; // [RQ16]
        susp_q <= 1'b0;
      end else if (state_q == sios_pkg::S_IRQ
                   && ph_q == sios_pkg::IRQ_LEN - 4'h1) begin
        susp_q <= 1'b1;
      end else if (elem_end && state_q == sios_pkg::S_ELEM
                   && (form_q != sios_pkg::FORM_INC_REPEAT
                       || cnt_dec == 16'h0)) begin
        done_q <= 1'b1;
      end
      if (elem_end && form_q == sios_pkg::FORM_INC_REPEAT
          && cnt_dec != 16'h0 && irq_req) begin
        saved_pc <= pc_q; // [RQ7]
      end
    end
  end

  // ---------------------------------------------------------------
  // memory read and io write path
  // ---------------------------------------------------------------
  logic [15:0] elem_data_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_rd <= 1'b0;
      mem_addr <= sios_pkg::RST_WORD;
    end else begin
      // first element reads at the end of setup, later ones at element end
      mem_rd <= ((state_q == sios_pkg::S_SETUP)
                 && form_q != sios_pkg::FORM_DIRECT
                 && (ph_q == sios_pkg::SETUP_BLOCK - 4'h1))
             || (elem_end && form_q == sios_pkg::FORM_INC_REPEAT
                 && cnt_dec != 16'h0 && !irq_req);
      // the pointer steps at element end, so read at its next value
      mem_addr <= elem_end ? step_ptr(src_q, byte_q, 1'b1)
                           : src_q; // [RQ1]
    end
  end

  // memory data arrives the cycle after mem_rd
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      elem_data_q <= sios_pkg::RST_WORD;
    end else if (state_q == sios_pkg::S_ELEM
                 && ph_q == sios_pkg::E_CAPT) begin
      if (form_q == sios_pkg::FORM_DIRECT) begin
        elem_data_q <= data_q; // [RQ11]
      end else if (byte_q) begin
        elem_data_q <= {8'h00, src_q[0] ? mem_rdata[7:0] : mem_rdata[15:8]};
      end else begin
        elem_data_q <= mem_rdata; // [RQ1]
      end
    end
  end

  sios_fifo #(
    .WIDTH(33),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({byte_q, dst_q, elem_data_q}),
    .out_valid(io_valid),
    .out_ready(io_ready),
    .out_data(fifo_out)
  );

  assign io_byte = fifo_out[32];
  assign io_addr = fifo_out[31:16]; // [RQ2]
  assign io_data = fifo_out[15:0];
  assign io_status = io_valid ? sios_pkg::STATUS_SPECIAL_IO
                              : sios_pkg::STATUS_IDLE; // [RQ10]

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start;
    state_q == sios_pkg::S_IDLE && $past(go) == 1'b0 ##0 go;
  endsequence

  a_trap_no_run : assert property (@(posedge ref_clk) disable iff (rst)
    go && !pwdata[sios_pkg::CTRL_PRIV] |=> priv_trap && !busy) // [RQ16]
    else $error("unprivileged start not trapped");
  a_priv_only : assert property (@(posedge ref_clk) disable iff (rst)
    $rose(busy) |-> $past(pwdata[sios_pkg::CTRL_PRIV])) // [RQ9]
    else $error("run started without privilege");
  a_inc_step : assert property (@(posedge ref_clk) disable iff (rst)
    elem_end && form_q == sios_pkg::FORM_INC_REPEAT
    |=> src_q == $past(src_q) + ($past(byte_q) ? 16'h1 : 16'h2)) // [RQ3]
    else $error("source pointer did not advance");
  a_dec_step : assert property (@(posedge ref_clk) disable iff (rst)
    elem_end && form_q == sios_pkg::FORM_DEC
    |=> src_q == $past(src_q) - ($past(byte_q) ? 16'h1 : 16'h2)) // [RQ13]
    else $error("source pointer did not step back");
  a_cnt_dec : assert property (@(posedge ref_clk) disable iff (rst)
    elem_end && form_q != sios_pkg::FORM_DIRECT
    |=> cnt_q == $past(cnt_q) - 16'h1) // [RQ4]
    else $error("counter not decremented");
  a_direct_len : assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busy) && form_q == sios_pkg::FORM_DIRECT && done_q
    |-> $past(cyc_q) == 16'd11 || $past(elem_q) == 16'h0) // [RQ11]
    else $error("direct form length wrong");
  a_block_len : assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busy) && form_q == sios_pkg::FORM_INC_REPEAT && done_q
    && !susp_q |-> cyc_q >= 16'd20) // [RQ6]
    else $error("repeat form too short");
  a_irq_seven : assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_q == sios_pkg::S_IRQ)
    |-> (state_q == sios_pkg::S_IRQ) [*7] ##1 !busy) // [RQ8]
    else $error("interrupt overhead not seven cycles");
  a_pc_saved : assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |-> saved_pc == pc_q && susp_q) // [RQ7]
    else $error("start pc not saved");
  a_io_status : assert property (@(posedge ref_clk) disable iff (rst)
    io_valid |-> io_status == sios_pkg::STATUS_SPECIAL_IO) // [RQ10]
    else $error("io without special status");
  a_direct_flags : assert property (@(posedge ref_clk) disable iff (rst) // [RQ12]
    busy && form_q == sios_pkg::FORM_DIRECT |=> flags_q == $past(flags_q))
    else $error("direct form changed flags");
  a_dec_flag : assert property (@(posedge ref_clk) disable iff (rst)
    elem_end && form_q == sios_pkg::FORM_DEC
    |=> flags_q[sios_pkg::FLG_V] == (cnt_q == 16'h0)) // [RQ14]
    else $error("overflow flag wrong after step");

endmodule : sios_top

// ==== verification/sios_mmu_model.sv ====
// behavioural model of the io-space consumer at the far side
module sios_mmu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic io_valid,
  output logic io_ready,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_data,
  input wire logic io_byte,
  input wire logic [3:0] io_status
);
  timeunit 1ns;
  timeprecision 1ns;
  // entries kept as {status, byte, address, data}
  logic [36:0] got_q[$];
  always @(posedge ref_clk) begin
    if (rst) begin
      io_ready <= 1'b0;
    end else begin
      // a stalled consumer lets the fifo fill up
      io_ready <= !stall;
      if (io_valid === 1'b1 && io_ready === 1'b1) begin
        got_q.push_back({io_status, io_byte, io_addr, io_data});
      end
    end
  end
endmodule : sios_mmu_model

// ==== verification/test_special_io_output_sequencer.sv ====
// self-checking bench for the special output sequencer
module test_special_io_output_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, mem_rd, err;
  logic irq_req, irq_ack, priv_trap, io_valid, io_ready, io_byte, stall;
  logic trap_seen, ack_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, saved_pc, rd;
  logic [15:0] mem_addr, mem_rdata, io_addr, io_data;
  logic [3:0] io_status;
  int n_errors, cmp_count, n_cyc;

  sios_top #(.FIFO_DEPTH(32)) dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .irq_ack(irq_ack), .saved_pc(saved_pc),
    .priv_trap(priv_trap), .io_valid(io_valid), .io_ready(io_ready),
    .io_addr(io_addr), .io_data(io_data), .io_byte(io_byte),
    .io_status(io_status));
  sios_mmu_model mmu (.ref_clk(ref_clk), .rst(rst), .stall(stall),
    .io_valid(io_valid), .io_ready(io_ready), .io_addr(io_addr),
    .io_data(io_data), .io_byte(io_byte), .io_status(io_status));

  // ---------------------------------------------------------------
  // clock, memory model, monitors and timeout
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] elem(input logic [15:0] s, input logic b);
    if (b) begin
      return {8'h00, s[0] ? ~s[8:1] : s[8:1]};
    end
    return {s[8:1], ~s[8:1]};
  endfunction : elem
  // read data valid one cycle after the strobe, scrambled otherwise
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd ? elem(mem_addr & 16'hFFFE, 1'b0) : ~mem_rdata;
    n_cyc <= n_cyc + 1;
    if (priv_trap === 1'b1) trap_seen <= 1'b1;
    if (irq_ack === 1'b1) ack_seen <= 1'b1;
    if (n_cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic io_chk(input logic [15:0] a, input logic [15:0] d,
                        input logic b);
    logic [36:0] g;
    g = (mmu.got_q.size() > 0) ? mmu.got_q.pop_front() : '1;
    chk("io addr", {16'h0, a}, {16'h0, g[31:16]});
    chk("io status", {27'h0, sios_pkg::STATUS_SPECIAL_IO, b},
        {27'h0, g[36:32]});
    chk("io data", {16'h0, d}, {16'h0, b ? {8'h0, g[7:0]} : g[15:0]});
  endtask : io_chk
  task automatic go(input logic [1:0] f, input logic b, input logic p);
    apb(1'b1, sios_pkg::OFS_CTRL, {27'h0, p, b, f, 1'b1});
  endtask : go
  task automatic wait_idle;
    do apb(1'b0, sios_pkg::OFS_STAT, 32'h0); while (rd[0] === 1'b1);
  endtask : wait_idle
  task automatic setup(input logic [15:0] s, input logic [15:0] c,
                       input logic [15:0] f);
    apb(1'b1, sios_pkg::OFS_SRC, {16'h0, s});
    apb(1'b1, sios_pkg::OFS_CNT, {16'h0, c});
    apb(1'b1, sios_pkg::OFS_DST, 32'h0000_0040);
    apb(1'b1, sios_pkg::OFS_FLAGS, {16'h0, f});
  endtask : setup
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_map;
    for (int i = 1; i < 9; i++) begin
      rdchk("reset value", 8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_map
  task automatic t_direct;
    for (int b = 0; b < 2; b++) begin
      setup(16'h0, 16'h1, 16'h0035);
      apb(1'b1, sios_pkg::OFS_DATA, 32'h0000_12AB);
      go(sios_pkg::FORM_DIRECT, 1'(b), 1'b1);
      wait_idle();
      rdchk("direct cycles", sios_pkg::OFS_CYC, 32'd12);
      rdchk("direct flags", sios_pkg::OFS_FLAGS, 32'h35);
      io_chk(16'h0040, b ? 16'h00AB : 16'h12AB, 1'(b));
    end
  endtask : t_direct
  task automatic t_inc_byte;
    setup(16'h0101, 16'h3, 16'h0035);
    go(sios_pkg::FORM_INC_REPEAT, 1'b1, 1'b1);
    wait_idle();
    rdchk("repeat cycles", sios_pkg::OFS_CYC, 32'd41);
    rdchk("byte src", sios_pkg::OFS_SRC, 32'h104);
    rdchk("counter", sios_pkg::OFS_CNT, 32'h0);
    rdchk("repeat flags", sios_pkg::OFS_FLAGS, 32'h3D);
    for (int i = 0; i < 3; i++) begin
      io_chk(16'h0040, elem(16'h0101 + 16'(i), 1'b1), 1'b1);
    end
  endtask : t_inc_byte
  task automatic t_fill;
    stall <= 1'b1;
    setup(16'h0200, 16'd34, 16'h0);
    go(sios_pkg::FORM_INC_REPEAT, 1'b0, 1'b1);
    repeat (450) @(posedge ref_clk);
    rdchk("full fifo stalls", sios_pkg::OFS_STAT, 32'h1);
    stall <= 1'b0;
    wait_idle();
    rdchk("word src", sios_pkg::OFS_SRC, 32'h244);
    // let the consumer drain the entries still left in the fifo
    repeat (60) @(posedge ref_clk);
    chk("io count", 32'd34, 32'(mmu.got_q.size()));
    for (int i = 0; i < 34; i++) begin
      io_chk(16'h0040, elem(16'h0200 + 16'(2 * i), 1'b0), 1'b0);
    end
  endtask : t_fill
  task automatic t_irq;
    setup(16'h0300, 16'h2, 16'h0);
    apb(1'b1, sios_pkg::OFS_PC, 32'h0000_1234);
    ack_seen = 1'b0;
    irq_req <= 1'b1;
    go(sios_pkg::FORM_INC_REPEAT, 1'b0, 1'b1);
    wait_idle();
    chk("suspended", 32'h8, rd & 32'h9);
    chk("irq ack", 32'h1, {31'h0, ack_seen});
    chk("saved pc", 32'h1234, saved_pc);
    rdchk("irq cycles", sios_pkg::OFS_CYC, 32'd28);
    rdchk("irq counter", sios_pkg::OFS_CNT, 32'h1);
    irq_req <= 1'b0;
    go(sios_pkg::FORM_INC_REPEAT, 1'b0, 1'b1);
    wait_idle();
    rdchk("resume cycles", sios_pkg::OFS_CYC, 32'd21);
    rdchk("resume src", sios_pkg::OFS_SRC, 32'h304);
    io_chk(16'h0040, elem(16'h0300, 1'b0), 1'b0);
    io_chk(16'h0040, elem(16'h0302, 1'b0), 1'b0);
  endtask : t_irq
  task automatic t_dec;
    for (int b = 0; b < 2; b++) begin
      setup(16'h0501, 16'(b + 1), 16'h003D);
      go(sios_pkg::FORM_DEC, 1'(b), 1'b1);
      wait_idle();
      rdchk("dec cycles", sios_pkg::OFS_CYC, 32'd21);
      rdchk("dec src", sios_pkg::OFS_SRC, b ? 32'h500 : 32'h4FF);
      rdchk("dec count", sios_pkg::OFS_CNT, 32'(b));
      rdchk("dec flags", sios_pkg::OFS_FLAGS, b ? 32'h35 : 32'h3D);
      io_chk(16'h0040, elem(16'h0501, 1'(b)), 1'(b));
    end
  endtask : t_dec
  task automatic t_priv;
    setup(16'h0600, 16'h2, 16'h0);
    trap_seen = 1'b0;
    go(sios_pkg::FORM_INC_REPEAT, 1'b0, 1'b0);
    wait_idle();
    chk("trap status", 32'h4, rd & 32'h5);
    chk("trap pulse", 32'h1, {31'h0, trap_seen});
    rdchk("trap src", sios_pkg::OFS_SRC, 32'h600);
    chk("trap no io", 32'h0, 32'(mmu.got_q.size()));
  endtask : t_priv

  initial begin
    {rst, psel, penable, pwrite, irq_req, stall} = 6'b100000;
    {trap_seen, ack_seen} = 2'b00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_rdata = 16'h0000;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_map();
    t_direct();
    t_inc_byte();
    t_fill();
    t_irq();
    t_dec();
    t_priv();
    complete_run();
  end
endmodule : test_special_io_output_sequencer
